// ==== design/mrtir_router.sv ====
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
// Function
// (R1) In RTU mode the inter-character timeout is 10 to 500 ms, or 1.5 character times when zero.
// (R2) Above 19200 bps fixed internal gap values replace the user settings.
// (R3) A character arriving after more than the inter-character timeout discards the frame.
// (R4) After an RTU response the next RTU request waits the inter-frame delay (10-500 ms, 0 = 3.5 chars).
// (R5) One character time is eleven bit periods at the current baud rate.
// (R6) With an attached serial slave the default map sends every id to the serial port; the code's default entry covers ids 1 to 254 only.
// (R7) With an attached serial master, software adds each map entry, giving IP and TCP port 1-65535.
// (R8) Each entry holds a start and end virtual id from 1 to 254 selecting its target.
// (R9) The real id is the virtual id plus the entry's signed offset of -253 to 253.
// (R10) A matching request goes only to its entry's network with the real id, never broadcast.
// (R11) A request matching no virtual range is dropped silently.
// (R12) Software keeps virtual ranges free of overlap.
// (R13) A serial request is abandoned after the 10 to 120000 ms response timeout, default 1000.
// (R14) Serial requests go out one at a time, each waiting for response or timeout.
// (R15) A character-time tick derived from baud rate and clock drives both gap counters; the code's half-character tick drives only gap_half_q.
module mrtir_router #(
  parameter int unsigned NUM_ENTRIES = mrtir_pkg::ENT_MAX
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  input wire logic ser_char_in,
  input wire logic ser_frame_end_in,
  output logic ser_discard_out,
  input wire logic req_valid_in,
  input wire mrtir_pkg::mrtir_req_t req_in,
  output logic req_ready_out,
  output logic fwd_valid_out,
  input wire logic fwd_ready_in,
  output mrtir_pkg::mrtir_fwd_t fwd_out
);
  import mrtir_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic [19:0] gap_ms_us(input logic [8:0] ms);
    logic [8:0] c;
    c = (ms < GAP_MS_MIN) ? GAP_MS_MIN : (ms > GAP_MS_MAX) ? GAP_MS_MAX : ms;
    return 20'(c) * 20'(MS_US);
  endfunction

  // ***********************************************************
  // Registers
  // ***********************************************************
  logic [1:0] ctrl_q, ctrl_d;
  logic [23:0] baud_q, baud_d;
  logic [8:0] ict_q, ict_d, ifd_q, ifd_d;
  logic [16:0] rsp_q, rsp_d;
  logic [EV_W-1:0] status_q, status_d, mask_q, mask_d, ev;
  mrtir_entry_t ent_q [NUM_ENTRIES];
  mrtir_entry_t ent_d [NUM_ENTRIES];
  logic [31:0] ip_q [NUM_ENTRIES];
  logic [31:0] ip_d [NUM_ENTRIES];
  logic [15:0] port_q [NUM_ENTRIES];
  logic [15:0] port_d [NUM_ENTRIES];
  logic rd_ack_q, rd_ack_d;
  logic [31:0] rdata_q, rdata_d, rmux;
  logic wr, ent_acc, ascii, fast;
  logic [1:0] ent_idx;
  mrtir_st_t st_q, st_d;
  logic in_frame_q;

  always_comb begin
    wr = avs_write_in && !avs_read_in;
    ent_acc = avs_address_in[7:6] == ENT_REGION;
    ent_idx = avs_address_in[5:4];
    avs_waitrequest_out = avs_read_in && !rd_ack_q;
    rd_ack_d = avs_read_in && !rd_ack_q;
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    ict_d = ict_q;
    ifd_d = ifd_q;
    rsp_d = rsp_q;
    mask_d = mask_q;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      ent_d[i] = ent_q[i];
      ip_d[i] = ip_q[i];
      port_d[i] = port_q[i];
    end
    rmux = '0;
    if (ent_acc) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        if (ent_idx == 2'(i)) begin
          case (avs_address_in[3:2])
            ENT_WORD_CFG: begin
              rmux = 32'(ent_q[i]);
              if (wr) begin
                ent_d[i] = mrtir_entry_t'(28'(merge(32'(ent_q[i]), avs_writedata_in,
                                                    avs_byteenable_in)));
              end
            end
            ENT_WORD_IP: begin
              rmux = ip_q[i];
              if (wr) begin
                ip_d[i] = merge(ip_q[i], avs_writedata_in, avs_byteenable_in);
              end
            end
            ENT_WORD_PORT: begin
              rmux = 32'(port_q[i]);
              if (wr) begin
                port_d[i] = 16'(merge(32'(port_q[i]), avs_writedata_in, avs_byteenable_in));
              end
            end
            default: rmux = '0;
          endcase
        end
      end
    end else begin
      case (avs_address_in)
        REG_CTRL: rmux = 32'(ctrl_q);
        REG_BAUD: rmux = 32'(baud_q);
        REG_ICT: rmux = 32'(ict_q);
        REG_IFD: rmux = 32'(ifd_q);
        REG_RSP: rmux = 32'(rsp_q);
        REG_STATUS: rmux = 32'(status_q);
        REG_MASK: rmux = 32'(mask_q);
        REG_STATE: rmux = 32'({fast, in_frame_q, st_q});
        default: rmux = '0;
      endcase
      if (wr) begin
        case (avs_address_in)
          REG_CTRL: ctrl_d = 2'(merge(32'(ctrl_q), avs_writedata_in, avs_byteenable_in));
          REG_BAUD: baud_d = 24'(merge(32'(baud_q), avs_writedata_in, avs_byteenable_in));
          REG_ICT: ict_d = 9'(merge(32'(ict_q), avs_writedata_in, avs_byteenable_in));
          REG_IFD: ifd_d = 9'(merge(32'(ifd_q), avs_writedata_in, avs_byteenable_in));
          REG_RSP: rsp_d = 17'(merge(32'(rsp_q), avs_writedata_in, avs_byteenable_in));
          REG_MASK: mask_d = EV_W'(merge(32'(mask_q), avs_writedata_in, avs_byteenable_in));
          default: ;
        endcase
      end
    end
    rdata_d = rd_ack_d ? rmux : rdata_q;
    // Clear only the bits actually returned, so an event landing
    // between capture and the accepting edge survives; set wins
    status_d = status_q & ~((avs_read_in && rd_ack_q && !ent_acc
      && avs_address_in == REG_STATUS) ? rdata_q[EV_W-1:0] : '0);
    status_d = status_d | ev;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= '0;
      baud_q <= BAUD_RST;
      ict_q <= '0;
      ifd_q <= '0;
      rsp_q <= RSP_MS_RST;
      status_q <= '0;
      mask_q <= '0;
      rd_ack_q <= 1'b0;
      rdata_q <= '0;
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        ent_q[i] <= (i == 0) ? ENTRY_SLAVE_DEF : '0; // R6
        ip_q[i] <= '0;
        port_q[i] <= '0;
      end
    end else begin
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      ict_q <= ict_d;
      ifd_q <= ifd_d;
      rsp_q <= rsp_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rd_ack_q <= rd_ack_d;
      rdata_q <= rdata_d;
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        ent_q[i] <= ent_d[i];
        ip_q[i] <= ip_d[i];
        port_q[i] <= port_d[i];
      end
    end
  end

  assign avs_readdata_out = rdata_q;
  assign irq_out = |(status_q & mask_q);

  // ***********************************************************
  // Ticks: microsecond, millisecond and half character time
  // ***********************************************************
  logic [7:0] us_div_q, us_div_d;
  logic [9:0] ms_div_q, ms_div_d;
  logic [31:0] acc_q, acc_d, acc_sum;
  logic us_tick, ms_tick, half_tick;

  always_comb begin
    us_tick = us_div_q == 8'(CYC_PER_US - 1);
    us_div_d = us_tick ? '0 : us_div_q + 8'h01;
    ms_tick = us_tick && ms_div_q == 10'(MS_US - 1);
    ms_div_d = ms_tick ? '0 : (us_tick ? ms_div_q + 10'h001 : ms_div_q);
    // Accumulate baud per clock; wrapping at CLK_HZ*11/2 gives half a character
    acc_sum = acc_q + 32'(baud_q); // R5
    half_tick = acc_sum >= HALF_CHAR_UNITS; // R15
    acc_d = half_tick ? acc_sum - HALF_CHAR_UNITS : acc_sum;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      us_div_q <= '0;
      ms_div_q <= '0;
      acc_q <= '0;
    end else begin
      us_div_q <= us_div_d;
      ms_div_q <= ms_div_d;
      acc_q <= acc_d;
    end
  end

  // ***********************************************************
  // Receive gap timing
  // ***********************************************************
  logic [19:0] gap_us_q, gap_us_d, ict_us;
  logic [3:0] gap_half_q, gap_half_d;
  logic in_frame_d, ict_over, ifd_met, discard_q, discard_d;

  always_comb begin
    ascii = ctrl_q[CTRL_ASCII];
    fast = baud_q > FAST_BAUD;
    ict_us = fast ? FIXED_ICT_US : gap_ms_us(ict_q); // R2
    if (!fast && ict_q == '0) begin
      ict_over = gap_half_q > HALF_ICT; // R1
    end else begin
      ict_over = gap_us_q > ict_us; // R1
    end
    if (ascii) begin
      ifd_met = 1'b1;
    end else if (fast) begin
      ifd_met = gap_us_q >= FIXED_IFD_US; // R2
    end else if (ifd_q == '0) begin
      ifd_met = gap_half_q >= HALF_IFD; // R4
    end else begin
      ifd_met = gap_us_q >= gap_ms_us(ifd_q); // R4
    end
    discard_d = ser_char_in && in_frame_q && !ascii && ict_over; // R3
    gap_us_d = ser_char_in ? '0 : gap_us_q + 20'(us_tick && gap_us_q != '1);
    gap_half_d = ser_char_in ? '0 : gap_half_q + 4'(half_tick && gap_half_q != '1); // R15
    in_frame_d = ser_char_in || (in_frame_q && !ser_frame_end_in);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gap_us_q <= '1;
      gap_half_q <= '1;
      in_frame_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      gap_us_q <= gap_us_d;
      gap_half_q <= gap_half_d;
      in_frame_q <= in_frame_d;
      discard_q <= discard_d;
    end
  end

  assign ser_discard_out = discard_q;

  // ***********************************************************
  // Id lookup and request routing
  // ***********************************************************
  logic [NUM_ENTRIES-1:0] hit;
  logic [7:0] rid [NUM_ENTRIES];
  logic any_hit, tmo;
  logic [1:0] sel;
  mrtir_fwd_t fwd_q, fwd_d;
  logic [16:0] rsp_cnt_q, rsp_cnt_d, rsp_lim;

  for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_match
    mrtir_id_match u_match (
      .entry_in(ent_q[g]),
      .vid_in(req_in.vid),
      .hit_out(hit[g]),
      .rid_out(rid[g])
    );
  end

  always_comb begin
    any_hit = |hit; // R8
    sel = '0;
    // Lowest entry wins; overlap is software's to avoid
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        sel = 2'(i);
      end
    end
    rsp_lim = (rsp_q < RSP_MS_MIN) ? RSP_MS_MIN : (rsp_q > RSP_MS_MAX) ? RSP_MS_MAX : rsp_q;
    tmo = ms_tick && rsp_cnt_q >= rsp_lim - 17'h00001; // R13
    st_d = st_q;
    fwd_d = fwd_q;
    rsp_cnt_d = rsp_cnt_q;
    ev = '0;
    ev[EV_DISCARD] = discard_d;
    req_ready_out = st_q == ST_IDLE; // R14
    case (st_q)
      ST_IDLE: begin
        if (req_valid_in) begin
          if (any_hit) begin
            fwd_d.tgt = ent_q[sel].tgt; // R10
            fwd_d.entry = sel;
            fwd_d.ip = ip_q[sel];
            fwd_d.port = port_q[sel];
            fwd_d.rid = rid[sel]; // R9
            fwd_d.tag = req_in.tag;
            st_d = ST_SEND;
          end else begin
            ev[EV_DROP] = 1'b1; // R11
          end
        end
      end
      ST_SEND: begin
        if (fwd_ready_in) begin
          ev[EV_FWD] = 1'b1;
          rsp_cnt_d = '0;
          st_d = (fwd_q.tgt == TGT_SERIAL) ? ST_WAIT : ST_IDLE; // R14
        end
      end
      ST_WAIT: begin
        if (ser_frame_end_in) begin
          ev[EV_RSP] = 1'b1;
          st_d = ST_GAP;
        end else if (tmo) begin
          ev[EV_TMO] = 1'b1; // R13
          st_d = ST_GAP;
        end else if (ms_tick) begin
          rsp_cnt_d = rsp_cnt_q + 17'h00001;
        end
      end
      ST_GAP: begin
        if (ifd_met) begin
          st_d = ST_IDLE; // R4
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= ST_IDLE;
      fwd_q <= '0;
      rsp_cnt_q <= '0;
    end else begin
      st_q <= st_d;
      fwd_q <= fwd_d;
      rsp_cnt_q <= rsp_cnt_d;
    end
  end

  assign fwd_valid_out = st_q == ST_SEND;
  assign fwd_out = fwd_q;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  gap_discard_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R3
    ser_char_in && in_frame_q && !ascii && ict_over |=> ser_discard_out && status_q[EV_DISCARD])
    else $error("late character did not discard the frame");
  auto_ict_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R1
    ser_char_in && !fast && ict_q == '0 && gap_half_q <= HALF_ICT |=> !ser_discard_out)
    else $error("frame discarded within 1.5 character times");
  fast_gap_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R2
    ser_char_in && fast && gap_us_q <= FIXED_ICT_US |=> !ser_discard_out)
    else $error("user gap used above 19200 bps");
  drop_miss_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R11
    st_q == ST_IDLE && req_valid_in && !any_hit |=> st_q == ST_IDLE && !fwd_valid_out
      && status_q[EV_DROP])
    else $error("unmatched request was not dropped");
  real_id_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R9
    st_q == ST_IDLE && req_valid_in && any_hit |=> fwd_valid_out
      && fwd_out.rid == 8'($past(req_in.vid) + {{7{ent_q[fwd_out.entry].offset[8]}},
      ent_q[fwd_out.entry].offset[7:0]}) && fwd_out.tgt == ent_q[fwd_out.entry].tgt)
    else $error("forwarded id or target wrong");
  serial_one_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R14
    st_q == ST_SEND && fwd_ready_in && fwd_q.tgt == TGT_SERIAL |=> !req_ready_out[*2])
    else $error("serial request overlapped");
  rsp_tmo_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R13
    st_q == ST_WAIT && tmo && !ser_frame_end_in |=> st_q == ST_GAP && status_q[EV_TMO])
    else $error("response timeout not taken");
  ifd_hold_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R4
    st_q == ST_GAP && !ifd_met |=> st_q == ST_GAP && !req_ready_out)
    else $error("next request before inter-frame delay");
  half_tick_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R15
    half_tick && baud_q <= FAST_BAUD |=> !half_tick)
    else $error("character tick too fast");
endmodule // mrtir_router

// ==== pkg/mrtir_pkg.sv ====
package mrtir_pkg;
  // ***********************************************************
  // Clock and timing
  // ***********************************************************
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_NS;
  localparam int unsigned CYC_PER_US = US_NS / CLK_NS;
  localparam int unsigned MS_US = 1000;
  localparam int unsigned CHAR_BITS = 11;
  localparam logic [31:0] HALF_CHAR_UNITS = 32'(64'(CLK_HZ) * 64'(CHAR_BITS) / 64'd2);
  localparam logic [3:0] HALF_ICT = 4'h3;
  localparam logic [3:0] HALF_IFD = 4'h7;
  localparam logic [23:0] FAST_BAUD = 24'h004b00;
  localparam logic [19:0] FIXED_ICT_US = 20'h002ee;
  localparam logic [19:0] FIXED_IFD_US = 20'h006d6;
  localparam logic [8:0] GAP_MS_MIN = 9'h00a;
  localparam logic [8:0] GAP_MS_MAX = 9'h1f4;
  localparam logic [16:0] RSP_MS_MIN = 17'h0000a;
  localparam logic [16:0] RSP_MS_MAX = 17'h1d4c0;
  localparam logic [16:0] RSP_MS_RST = 17'h003e8;
  localparam logic [23:0] BAUD_RST = 24'h002580;
  localparam logic [7:0] VID_MIN = 8'h01;
  localparam logic [7:0] VID_MAX = 8'hfe;

  // ***********************************************************
  // Register map (byte addresses)
  // ***********************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_ICT = 8'h08;
  localparam logic [7:0] REG_IFD = 8'h0c;
  localparam logic [7:0] REG_RSP = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_MASK = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1c;
  localparam logic [1:0] ENT_REGION = 2'h1;
  localparam logic [1:0] ENT_WORD_CFG = 2'h0;
  localparam logic [1:0] ENT_WORD_IP = 2'h1;
  localparam logic [1:0] ENT_WORD_PORT = 2'h2;
  localparam int unsigned ENT_MAX = 4;
  localparam int unsigned CTRL_SER_MASTER = 0;
  localparam int unsigned CTRL_ASCII = 1;
  localparam int unsigned EV_DISCARD = 0;
  localparam int unsigned EV_DROP = 1;
  localparam int unsigned EV_TMO = 2;
  localparam int unsigned EV_FWD = 3;
  localparam int unsigned EV_RSP = 4;
  localparam int unsigned EV_W = 5;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [1:0] {
    TGT_SERIAL = 2'b00,
    TGT_TCP = 2'b01
  } mrtir_tgt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10,
    ST_GAP = 2'b11
  } mrtir_st_t;

  typedef struct packed {
    logic valid;
    mrtir_tgt_t tgt;
    logic signed [8:0] offset;
    logic [7:0] end_id;
    logic [7:0] start_id;
  } mrtir_entry_t;

  localparam mrtir_entry_t ENTRY_SLAVE_DEF = '{valid: 1'b1, tgt: TGT_SERIAL,
    offset: 9'h000, end_id: VID_MAX, start_id: VID_MIN};

  typedef struct packed {
    logic [7:0] tag;
    logic [7:0] vid;
  } mrtir_req_t;

  typedef struct packed {
    mrtir_tgt_t tgt;
    logic [1:0] entry;
    logic [31:0] ip;
    logic [15:0] port;
    logic [7:0] rid;
    logic [7:0] tag;
  } mrtir_fwd_t;
endpackage

// ==== design/mrtir_id_match.sv ====
`timescale 1ns/10ps
module mrtir_id_match (
  input wire mrtir_pkg::mrtir_entry_t entry_in,
  input wire logic [7:0] vid_in,
  output logic hit_out,
  output logic [7:0] rid_out
);
  import mrtir_pkg::*;

  logic [9:0] sum;

  always_comb begin
    // Offset is sign-extended; the real id wraps to 8 bits
    sum = {2'b00, vid_in} + {entry_in.offset[8], entry_in.offset};
    rid_out = sum[7:0];
    hit_out = entry_in.valid && vid_in >= VID_MIN && vid_in <= VID_MAX
      && vid_in >= entry_in.start_id && vid_in <= entry_in.end_id;
  end
endmodule // mrtir_id_match

// ==== test/mrtir_slave_model.sv ====
`timescale 1ns/10ps
module mrtir_slave_model
  import mrtir_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic fwd_valid_in,
  input wire mrtir_pkg::mrtir_fwd_t fwd_in,
  input wire logic [3:0] delay_in,
  output logic fwd_ready_out,
  output logic frame_end_out
);
  // ************************************
  // Serial slave: one request at a time
  // ************************************
  logic [4:0] cnt_q;
  logic busy_q;
  // Replies carry no character pulses so the inter-frame gap stays saturated
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      fwd_ready_out <= 1'b0;
      frame_end_out <= 1'b0;
    end else begin
      fwd_ready_out <= 1'b0;
      frame_end_out <= 1'b0;
      cnt_q <= cnt_q + 5'h01;
      if (!busy_q && !(fwd_valid_in && !fwd_ready_out)) begin
        cnt_q <= '0;
      end else if (cnt_q >= {1'b0, delay_in}) begin
        cnt_q <= '0;
        fwd_ready_out <= !busy_q;
        frame_end_out <= busy_q;
        busy_q <= !busy_q && fwd_in.tgt == TGT_SERIAL;
      end
    end
  end
endmodule // mrtir_slave_model

// ==== test/tb.sv ====
`timescale 1ns/10ps
module tb;
  import mrtir_pkg::*;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] avs_address_in = '0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [31:0] avs_readdata_out, q;
  logic avs_waitrequest_out, irq_out, ser_discard_out, req_ready_out;
  logic ser_char_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic ser_frame_end_in, fwd_valid_out, fwd_ready_in;
  mrtir_req_t req_in = '0;
  mrtir_fwd_t fwd_out;
  logic [3:0] dly = '0;
  logic [7:0] e_lo[4], e_hi[4], cv[$];
  logic [8:0] e_off[4];
  logic [1:0] e_tgt[4];
  logic e_ok[4];
  logic [31:0] e_ip[4];
  logic [15:0] e_port[4];
  int errors = 0;
  int checks_done = 0;
  int disc = 0;
  int n;

  mrtir_router uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .ser_char_in(ser_char_in), .ser_frame_end_in(ser_frame_end_in),
    .ser_discard_out(ser_discard_out), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .fwd_valid_out(fwd_valid_out),
    .fwd_ready_in(fwd_ready_in), .fwd_out(fwd_out));
  mrtir_slave_model partner (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .fwd_valid_in(fwd_valid_out), .fwd_in(fwd_out), .delay_in(dly),
    .fwd_ready_out(fwd_ready_in), .frame_end_out(ser_frame_end_in));

  always #2 ref_clk_in = ~ref_clk_in;
  always @(negedge ref_clk_in) if (ser_discard_out === 1'b1) disc++;

  // ************************************
  // Checking and bus tasks
  // ************************************
  task end_sim;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task check(input logic [67:0] got, input logic [67:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    logic w;
    int k;
    k = 0;
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(negedge ref_clk_in);
      w = avs_waitrequest_out;
      rd = avs_readdata_out;
      @(posedge ref_clk_in);
      k++;
      if (k > 50) begin
        errors++;
        end_sim();
      end
    end while (w !== 1'b0);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task wait_idle;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
      if (n > 500) begin
        errors++;
        end_sim();
      end
    end while (req_ready_out !== 1'b1);
  endtask

  // Lowest matching index wins, so scan downwards
  function automatic logic [68:0] route(input logic [7:0] vid, input logic [7:0] tag);
    route = '0;
    for (int i = 3; i >= 0; i--) begin
      if (e_ok[i] && vid >= VID_MIN && vid <= VID_MAX && vid >= e_lo[i] && vid <= e_hi[i])
        route = {1'b1, e_tgt[i], 2'(i), e_ip[i], e_port[i], 8'(vid + e_off[i][7:0]), tag};
    end
  endfunction

  task send(input logic [7:0] vid, input logic [7:0] tag);
    logic [68:0] e;
    e = route(vid, tag);
    @(posedge ref_clk_in);
    dly <= 4'($urandom);
    req_in <= {tag, vid};
    req_valid_in <= 1'b1;
    wait_idle();
    @(posedge ref_clk_in);
    req_valid_in <= 1'b0;
    n = 0;
    @(negedge ref_clk_in);
    if (!e[68]) check(fwd_valid_out, 1'b0);
    while (e[68] && !(fwd_valid_out === 1'b1 && fwd_ready_in === 1'b1)) begin
      @(negedge ref_clk_in);
      n++;
      if (n > 100) begin
        errors++;
        end_sim();
      end
    end
    if (e[68]) check(fwd_out, e[67:0]);
    if (e[68] && e[67:66] == TGT_SERIAL) begin
      @(negedge ref_clk_in);
      check(req_ready_out, 1'b0);
    end
  endtask

  task burst(input int nr);
    foreach (cv[k]) send(cv[k], 8'(k));
    for (int k = 0; k < nr; k++) send(8'($urandom), 8'(k + 64));
  endtask

  task cfg(input int i);
    logic [7:0] a;
    a = 8'h40 + 8'(16 * i);
    bus(1'b1, a, {4'h0, e_ok[i], e_tgt[i], e_off[i], e_hi[i], e_lo[i]}, q);
    bus(1'b1, a + 8'h04, e_ip[i], q);
    bus(1'b1, a + 8'h08, {16'h0, e_port[i]}, q);
    bus(1'b0, a, '0, q);
    check(q, {4'h0, e_ok[i], e_tgt[i], e_off[i], e_hi[i], e_lo[i]});
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk_in);
    errors++;
    end_sim();
  end

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    n = $urandom(32'hc5f5);
    e_ok = '{1'b1, 1'b0, 1'b0, 1'b0};
    e_tgt = '{TGT_SERIAL, TGT_SERIAL, TGT_SERIAL, TGT_SERIAL};
    e_lo = '{8'h01, 8'h00, 8'h00, 8'h00};
    e_hi = '{8'hfe, 8'h00, 8'h00, 8'h00};
    e_off = '{9'h000, 9'h000, 9'h000, 9'h000};
    e_ip = '{32'h0, 32'h0, 32'h0, 32'h0};
    e_port = '{16'h0, 16'h0, 16'h0, 16'h0};
    repeat (5) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    bus(1'b0, REG_BAUD, '0, q);
    check(q, 32'h00002580);
    bus(1'b0, REG_RSP, '0, q);
    check(q, 32'h000003e8);
    bus(1'b0, 8'h40, '0, q);
    check(q, 32'h0800fe01);
    bus(1'b0, 8'h30, '0, q);
    check(q, 32'h0);
    cv = '{8'h01, 8'hfe, 8'h00, 8'hff};
    burst(10);
    wait_idle();
    bus(1'b0, REG_STATUS, '0, q);
    check(q, 32'h1a);
    bus(1'b1, REG_MASK, 32'h2, q);
    send(8'h00, 8'h55);
    repeat (2) @(negedge ref_clk_in);
    check(irq_out, 1'b1);
    bus(1'b0, REG_STATUS, '0, q);
    check(q, 32'h2);
    repeat (2) @(negedge ref_clk_in);
    check(irq_out, 1'b0);
    bus(1'b1, REG_MASK, 32'h0, q);
    send(8'h00, 8'h56);
    repeat (2) @(negedge ref_clk_in);
    check(irq_out, 1'b0);
    bus(1'b0, REG_STATUS, '0, q);
    check(q, 32'h2);
    e_hi[0] = 8'd50;
    e_off[0] = 9'h005;
    e_ok[1] = 1'b1;
    e_tgt[1] = TGT_TCP;
    e_lo[1] = 8'd100;
    e_hi[1] = 8'd110;
    e_off[1] = 9'h1f5;
    e_ip[1] = 32'h0a000002;
    e_port[1] = 16'h0001;
    e_ok[2] = 1'b1;
    e_tgt[2] = TGT_TCP;
    e_lo[2] = 8'd254;
    e_hi[2] = 8'd254;
    e_off[2] = 9'h103;
    e_ip[2] = 32'h0a000003;
    e_port[2] = 16'hffff;
    for (int i = 0; i < 4; i++) cfg(i);
    cv = '{8'd50, 8'd51, 8'd100, 8'd110, 8'd111, 8'd254};
    burst(16);
    bus(1'b1, REG_BAUD, 32'h9600, q);
    bus(1'b0, REG_STATE, '0, q);
    check(q[3], 1'b1);
    bus(1'b1, REG_BAUD, 32'h4b00, q);
    bus(1'b0, REG_STATE, '0, q);
    check(q[3], 1'b0);
    wait_idle();
    // Characters close together must never be taken for a broken frame
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk_in);
      ser_char_in <= 1'b1;
      @(posedge ref_clk_in);
      ser_char_in <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
    end
    bus(1'b0, REG_STATE, '0, q);
    check(q[2], 1'b1);
    check(disc, 0);
    // The last character restarted the gap, so a served request holds off the next
    send(8'd50, 8'h77);
    repeat (40) @(negedge ref_clk_in);
    check(req_ready_out, 1'b0);
    bus(1'b1, REG_CTRL, 32'h2, q);
    wait_idle();
    bus(1'b0, REG_STATE, '0, q);
    check(q[1:0], ST_IDLE);
    end_sim();
  end
endmodule // tb
